// [sfg_defines.svh]
// Constants of the serial flash write guard
// How it works
// RQ1: Reset input holds every operation off and ignores all instructions.
// RQ2: After reset, writing instructions stay refused for a cycle-count delay.
// RQ3: Write latch flag starts at zero after power-up.
// RQ4: Program, erase and status write need the write latch flag set.
// RQ5: Finished program, erase or status write clears the write latch flag.
// RQ6: Power-down ignores every instruction except release power-down.
// RQ7: Busy bit S0 reads one while an operation runs, zero after.
// RQ8: While busy only status reads are served.
// RQ9: Write enable sets the write latch flag in bit S1.
// RQ10: Write disable and every write instruction clear the write latch flag; a refused program, erase or status write here leaves it set.
// RQ11: Guard bits sit at S4..S2, status-writable, default zero.
// RQ12: Lock bit one and protect pin low freeze the guard bits.
// RQ13: Small variants ignore the top guard bit.
// RQ14: Status bits five and six always read zero.
// RQ15: Host should mask the reserved status bits.
// RQ16: Lock bit S7 defaults zero; then the protect pin is ignored.
// RQ17: Lock bit one refuses status writes while pin low, allows when high.
// RQ18: Four-megabit decode protects from 70000h, 60000h, 40000h or all.
// RQ19: Two-megabit decode protects none, from 30000h, 20000h, or all.
// RQ20: One-megabit array protected only when both low guard bits set.
// RQ21: Program and erase into a guarded region are refused.
// RQ22: Status write changes only lock and used guard bits.
// RQ23: Status byte read with opcode 05h, MSB first, even when busy.
// RQ24: Status write is opcode 01h plus one byte, needs the latch.
// RQ25: Density is a build parameter selecting decode and write mask.
// RQ26: Power-up delay is a reset input plus a cycle-count delay.
`ifndef SFG_DEFINES_SVH
`define SFG_DEFINES_SVH
`define SFG_OP_WRSR 8'h01
`define SFG_OP_PP 8'h02
`define SFG_OP_WRDI 8'h04
`define SFG_OP_RDSR 8'h05
`define SFG_OP_WREN 8'h06
`define SFG_OP_BE 8'hc7
`define SFG_OP_SE 8'hd8
`define SFG_OP_PD 8'hb9
`define SFG_OP_RES 8'hab
`define SFG_BIT_BUSY 0
`define SFG_BIT_LATCH 1
`define SFG_BIT_LOCK 7
`define SFG_MASK_4M 8'h9c
`define SFG_MASK_SMALL 8'h8c
`define SFG_P40_B1 24'h070000
`define SFG_P40_B2 24'h060000
`define SFG_P40_B3 24'h040000
`define SFG_P20_B1 24'h030000
`define SFG_P20_B2 24'h020000
`define SFG_DENS_1M 1
`define SFG_DENS_2M 2
`define SFG_DENS_4M 4
`define SFG_BYTES_PER_MBIT 131072
`define SFG_WRSR_BYTES 3'h2
`define SFG_ADDR_BYTES 3'h4
`define SFG_CLK_MHZ 100
`define SFG_TPUW_US 10
`define SFG_TW_US 15
`endif

// [sfg_pkg.sv]
// Types shared by the serial flash write guard
package sfg_pkg;
   typedef enum logic [3:0] {
      SFG_ST_IDLE = 4'b0001,
      SFG_ST_PROG = 4'b0010,
      SFG_ST_WSR = 4'b0100,
      SFG_ST_PDOWN = 4'b1000
   } sfg_state_t;
   typedef enum logic [1:0] {
      SFG_K_NONE = 2'h0,
      SFG_K_PROG = 2'h1,
      SFG_K_SECT = 2'h2,
      SFG_K_BULK = 2'h3
   } sfg_kind_t;
   // Record of one serial frame, held steady while select is high
   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] data;
      logic [23:0] addr;
      logic [2:0] nbytes;
      logic aligned;
   } sfg_frame_t;
   typedef struct packed {
      sfg_kind_t kind;
      logic [23:0] addr;
   } sfg_array_req_t;
endpackage : sfg_pkg

// [sfg_sync.sv]
// Two-flop level synchroniser for a vector of independent flags
`timescale 1ns/1ps
module sfg_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   initial begin
      if (WIDTH < 1) $error("sfg_sync: WIDTH must be positive");
   end

   // First stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : sfg_sync

// [sfg_spi_link.sv]
// Serial clock side: shifts frames in and the status byte out
`timescale 1ns/1ps
`include "sfg_defines.svh"
module sfg_spi_link (
   input wire logic spi_clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic spi_di,
   input wire logic [7:0] status_view,
   input wire logic pdown_view,
   output sfg_pkg::sfg_frame_t frame,
   output logic frame_tgl,
   output logic spi_do,
   output logic spi_do_oe
);
   logic [2:0] bit_cnt;
   logic [2:0] byte_cnt;
   logic [6:0] shift;
   logic [2:0] next_bit_cnt;
   logic [2:0] next_byte_cnt;
   logic [6:0] next_shift;
   logic [7:0] byte_in;
   sfg_pkg::sfg_frame_t next_frame;
   logic next_tgl;
   logic reading;

   // Bit and byte counting within one select period
   always_comb begin
      byte_in = {shift, spi_di};
      next_shift = byte_in[6:0];
      next_bit_cnt = bit_cnt + 3'h1;
      next_byte_cnt = byte_cnt;
      if (bit_cnt == 3'h7 && byte_cnt != 3'h7) begin
         next_byte_cnt = byte_cnt + 3'h1;
      end
   end

   // Select high clears the counters between frames
   always_ff @(posedge spi_clk or posedge cs_n or negedge rst_n) begin
      if (!rst_n) begin // RQ1
         bit_cnt <= 3'h0;
         byte_cnt <= 3'h0;
         shift <= 7'h00;
      end else if (cs_n) begin
         bit_cnt <= 3'h0;
         byte_cnt <= 3'h0;
         shift <= 7'h00;
      end else begin
         bit_cnt <= next_bit_cnt;
         byte_cnt <= next_byte_cnt;
         shift <= next_shift;
      end
   end

   // Frame record, kept past the end of the frame
   always_comb begin
      next_frame = frame;
      next_tgl = frame_tgl;
      if (bit_cnt == 3'h0 && byte_cnt == 3'h0) begin
         next_frame = '0;
         next_tgl = ~frame_tgl; // Marks a new frame
      end
      next_frame.aligned = (bit_cnt == 3'h7);
      if (bit_cnt == 3'h7) begin
         next_frame.nbytes = next_byte_cnt;
         case (byte_cnt)
            3'h0: next_frame.opcode = byte_in;
            3'h1: begin
               next_frame.addr[23:16] = byte_in;
               next_frame.data = byte_in; // RQ24
            end
            3'h2: next_frame.addr[15:8] = byte_in;
            3'h3: next_frame.addr[7:0] = byte_in;
            default: next_frame.data = frame.data;
         endcase
      end
   end

   always_ff @(posedge spi_clk or negedge rst_n) begin
      if (!rst_n) begin
         frame <= '0;
         frame_tgl <= 1'b0;
      end else begin
         frame <= next_frame;
         frame_tgl <= next_tgl;
      end
   end

   // Status byte repeats MSB first, served even while busy
   always_comb begin
      reading = (byte_cnt != 3'h0) && !pdown_view && // RQ6
                (frame.opcode == `SFG_OP_RDSR); // RQ23
   end

   always_ff @(negedge spi_clk or posedge cs_n or negedge rst_n) begin
      if (!rst_n) begin
         spi_do <= 1'b0;
         spi_do_oe <= 1'b0;
      end else if (cs_n) begin
         spi_do <= 1'b0;
         spi_do_oe <= 1'b0;
      end else begin
         spi_do <= reading & status_view[3'h7 - bit_cnt]; // RQ23
         spi_do_oe <= reading;
      end
   end
endmodule : sfg_spi_link

// [sfg_write_guard.sv]
// Write guard top: status byte, latch, busy and region protection
`timescale 1ns/1ps
`include "sfg_defines.svh"
module sfg_write_guard #(
   parameter int DENSITY_MBIT = `SFG_DENS_4M, // RQ25
   parameter int PUW_CYCLES = `SFG_TPUW_US * `SFG_CLK_MHZ,
   parameter int TW_CYCLES = `SFG_TW_US * `SFG_CLK_MHZ
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic spi_clk,
   input wire logic spi_cs_n,
   input wire logic spi_di,
   input wire logic wp_n,
   input wire logic array_op_done,
   output logic spi_do,
   output logic spi_do_oe,
   output logic array_op_start,
   output sfg_pkg::sfg_array_req_t array_req,
   output logic [7:0] status_byte,
   output logic powered_down
);
   localparam int PW = $clog2(PUW_CYCLES + 1);
   localparam int TWW = $clog2(TW_CYCLES + 1);
   localparam logic [PW-1:0] PUW_LAST = PW'(PUW_CYCLES);
   localparam logic [TWW-1:0] TW_LAST = TWW'(TW_CYCLES - 1);
   localparam logic [7:0] WMASK = (DENSITY_MBIT == `SFG_DENS_4M) ?
      `SFG_MASK_4M : `SFG_MASK_SMALL;
   localparam logic [2:0] GMASK = WMASK[4:2];
   localparam logic [23:0] ARRAY_TOP =
      24'(DENSITY_MBIT * `SFG_BYTES_PER_MBIT - 1);

   initial begin
      if (DENSITY_MBIT != `SFG_DENS_1M && DENSITY_MBIT != `SFG_DENS_2M &&
          DENSITY_MBIT != `SFG_DENS_4M)
         $error("sfg_write_guard: DENSITY_MBIT must be 1, 2 or 4");
      if (PUW_CYCLES < 1 || TW_CYCLES < 1)
         $error("sfg_write_guard: delay counts must be positive");
   end

   // ------------------------------------------------------------
   // Crossings
   // ------------------------------------------------------------
   sfg_pkg::sfg_frame_t frm;
   logic frame_tgl;
   logic [2:0] sys_in;
   logic cs_s;
   logic tgl_s;
   logic wp_s;
   logic [8:0] link_view;

   sfg_sync #(.WIDTH(3), .RST_VAL(3'h5)) u_sys_sync (
      .clk(clk_sys),
      .rst_n(rst_n),
      .d({spi_cs_n, frame_tgl, wp_n}),
      .q(sys_in)
   );
   assign cs_s = sys_in[2];
   assign tgl_s = sys_in[1];
   assign wp_s = sys_in[0];

   sfg_sync #(.WIDTH(9), .RST_VAL(9'h000)) u_link_sync (
      .clk(spi_clk),
      .rst_n(rst_n),
      .d({powered_down, status_byte}),
      .q(link_view)
   );

   sfg_spi_link u_link (
      .spi_clk(spi_clk),
      .rst_n(rst_n),
      .cs_n(spi_cs_n),
      .spi_di(spi_di),
      .status_view(link_view[7:0]),
      .pdown_view(link_view[8]),
      .frame(frm),
      .frame_tgl(frame_tgl),
      .spi_do(spi_do),
      .spi_do_oe(spi_do_oe)
   );

   // ------------------------------------------------------------
   // Frame end detection
   // ------------------------------------------------------------
   logic cs_prev;
   logic tgl_seen;
   logic next_tgl_seen;
   logic cs_rise;
   logic frame_end;

   // A frame ends on select rising after at least one clock
   always_comb begin
      cs_rise = cs_s & ~cs_prev;
      frame_end = cs_rise & (tgl_s != tgl_seen);
      next_tgl_seen = cs_rise ? tgl_s : tgl_seen;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cs_prev <= 1'b1;
         tgl_seen <= 1'b0;
      end else begin
         cs_prev <= cs_s;
         tgl_seen <= next_tgl_seen;
      end
   end

   // ------------------------------------------------------------
   // Power-up write delay
   // ------------------------------------------------------------
   logic [PW-1:0] puw_cnt;
   logic [PW-1:0] next_puw_cnt;
   logic puw_done;

   always_comb begin
      puw_done = (puw_cnt == PUW_LAST); // RQ26
      next_puw_cnt = puw_done ? puw_cnt : puw_cnt + PW'(1);
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         puw_cnt <= '0;
      end else begin
         puw_cnt <= next_puw_cnt;
      end
   end

   // ------------------------------------------------------------
   // Region decode
   // ------------------------------------------------------------
   function automatic logic guarded(input logic [2:0] g,
                                    input logic [23:0] a);
      logic hit;
      hit = 1'b0;
      if (DENSITY_MBIT == `SFG_DENS_4M) begin
         if (g[2]) begin
            hit = 1'b1; // RQ18
         end else begin
            case (g[1:0])
               2'h1: hit = (a >= `SFG_P40_B1); // RQ18
               2'h2: hit = (a >= `SFG_P40_B2);
               2'h3: hit = (a >= `SFG_P40_B3);
               default: hit = 1'b0;
            endcase
         end
      end else if (DENSITY_MBIT == `SFG_DENS_2M) begin
         case (g[1:0]) // RQ13
            2'h1: hit = (a >= `SFG_P20_B1); // RQ19
            2'h2: hit = (a >= `SFG_P20_B2);
            2'h3: hit = 1'b1;
            default: hit = 1'b0;
         endcase
      end else begin
         hit = (g[1:0] == 2'h3); // RQ20 RQ13
      end
      return hit;
   endfunction : guarded

   // ------------------------------------------------------------
   // Instruction gating and status state
   // ------------------------------------------------------------
   sfg_pkg::sfg_state_t state;
   sfg_pkg::sfg_state_t next_state;
   logic write_latch_flag;
   logic lock;
   logic [2:0] guard;
   logic [7:0] pend;
   logic [TWW-1:0] tw_cnt;
   logic next_write_latch_flag;
   logic next_lock;
   logic [2:0] next_guard;
   logic [7:0] next_pend;
   logic [TWW-1:0] next_tw_cnt;
   logic next_start;
   sfg_pkg::sfg_array_req_t next_req;
   logic [7:0] next_status;
   logic busy;
   logic next_busy;
   logic write_ok;
   logic lock_out;

   assign busy = (state == sfg_pkg::SFG_ST_PROG) ||
                 (state == sfg_pkg::SFG_ST_WSR);

   always_comb begin
      next_state = state;
      next_write_latch_flag = write_latch_flag;
      next_lock = lock;
      next_guard = guard;
      next_pend = pend;
      next_tw_cnt = tw_cnt;
      next_start = 1'b0;
      next_req = array_req;
      write_ok = puw_done && write_latch_flag && frm.aligned; // RQ2 RQ4
      lock_out = lock && !wp_s; // RQ16 RQ17
      case (state)
         sfg_pkg::SFG_ST_IDLE: begin
            if (frame_end) begin
               case (frm.opcode)
                  `SFG_OP_WREN: begin
                     if (puw_done && frm.aligned)
                        next_write_latch_flag = 1'b1; // RQ9
                  end
                  `SFG_OP_WRDI: next_write_latch_flag = 1'b0; // RQ10
                  `SFG_OP_WRSR: begin
                     if (write_ok && !lock_out && // RQ12
                         frm.nbytes >= `SFG_WRSR_BYTES) begin
                        next_pend = frm.data; // RQ24
                        next_tw_cnt = '0;
                        next_state = sfg_pkg::SFG_ST_WSR;
                     end
                  end
                  `SFG_OP_PP, `SFG_OP_SE: begin
                     if (write_ok && frm.nbytes >= `SFG_ADDR_BYTES &&
                         !guarded(guard, frm.addr)) begin // RQ21
                        next_start = 1'b1;
                        next_req.addr = frm.addr;
                        next_req.kind = (frm.opcode == `SFG_OP_PP) ?
                           sfg_pkg::SFG_K_PROG : sfg_pkg::SFG_K_SECT;
                        next_state = sfg_pkg::SFG_ST_PROG;
                     end
                  end
                  `SFG_OP_BE: begin
                     if (write_ok && !guarded(guard, ARRAY_TOP)) begin
                        next_start = 1'b1;
                        next_req.addr = '0;
                        next_req.kind = sfg_pkg::SFG_K_BULK;
                        next_state = sfg_pkg::SFG_ST_PROG;
                     end
                  end
                  `SFG_OP_PD: next_state = sfg_pkg::SFG_ST_PDOWN;
                  default: next_state = sfg_pkg::SFG_ST_IDLE;
               endcase
            end
         end
         sfg_pkg::SFG_ST_PROG: begin
            // Frames are dropped here; status reads go out on the link
            if (array_op_done) begin // RQ8
               next_write_latch_flag = 1'b0; // RQ5
               next_state = sfg_pkg::SFG_ST_IDLE;
            end
         end
         sfg_pkg::SFG_ST_WSR: begin
            if (tw_cnt == TW_LAST) begin
               // Only lock and used guard bits change
               next_lock = pend[`SFG_BIT_LOCK] & WMASK[`SFG_BIT_LOCK] |
                           lock & ~WMASK[`SFG_BIT_LOCK]; // RQ22
               next_guard = (pend[4:2] & GMASK) |
                            (guard & ~GMASK); // RQ11 RQ22
               next_write_latch_flag = 1'b0; // RQ5 RQ10
               next_state = sfg_pkg::SFG_ST_IDLE;
            end else begin
               next_tw_cnt = tw_cnt + TWW'(1);
            end
         end
         sfg_pkg::SFG_ST_PDOWN: begin
            if (frame_end && frm.opcode == `SFG_OP_RES) // RQ6
               next_state = sfg_pkg::SFG_ST_IDLE;
         end
         default: next_state = sfg_pkg::SFG_ST_IDLE;
      endcase
      next_busy = (next_state == sfg_pkg::SFG_ST_PROG) ||
                  (next_state == sfg_pkg::SFG_ST_WSR); // RQ7
      next_status = {next_lock, 2'b00, next_guard, // RQ14
                     next_write_latch_flag, next_busy};
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin // RQ1 RQ3
         state <= sfg_pkg::SFG_ST_IDLE;
         write_latch_flag <= 1'b0;
         lock <= 1'b0;
         guard <= 3'h0;
         pend <= 8'h00;
         tw_cnt <= '0;
         array_op_start <= 1'b0;
         array_req <= '0;
         status_byte <= 8'h00;
         powered_down <= 1'b0;
      end else begin
         state <= next_state;
         write_latch_flag <= next_write_latch_flag;
         lock <= next_lock;
         guard <= next_guard;
         pend <= next_pend;
         tw_cnt <= next_tw_cnt;
         array_op_start <= next_start;
         array_req <= next_req;
         status_byte <= next_status;
         powered_down <= (next_state == sfg_pkg::SFG_ST_PDOWN);
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   logic is_write_op;
   assign is_write_op = (frm.opcode == `SFG_OP_PP) ||
                        (frm.opcode == `SFG_OP_SE) ||
                        (frm.opcode == `SFG_OP_BE) ||
                        (frm.opcode == `SFG_OP_WRSR);

   a_puw_no_latch: assert property ( // RQ2
      !puw_done |=> !status_byte[`SFG_BIT_LATCH])
      else $error("write latch set inside power-up delay");
   a_busy_bit: assert property ( // RQ7
      $rose(busy) |-> $past(frame_end) && $past(write_latch_flag))
      else $error("busy set without an accepted instruction");
   a_latch_needed: assert property ( // RQ4
      (state == sfg_pkg::SFG_ST_IDLE && frame_end && is_write_op &&
       !write_latch_flag)
      |=> !array_op_start && state == sfg_pkg::SFG_ST_IDLE)
      else $error("write started without write latch");
   a_done_clears: assert property ( // RQ5
      (state == sfg_pkg::SFG_ST_PROG && array_op_done)
      |=> !status_byte[`SFG_BIT_LATCH] && !status_byte[`SFG_BIT_BUSY])
      else $error("latch or busy left set after operation");
   a_lock_refuse: assert property ( // RQ17
      (state == sfg_pkg::SFG_ST_IDLE && frame_end &&
       frm.opcode == `SFG_OP_WRSR && lock && !wp_s)
      |=> state == sfg_pkg::SFG_ST_IDLE && $stable(guard))
      else $error("status write accepted while locked");
   a_pdown_hold: assert property ( // RQ6
      (state == sfg_pkg::SFG_ST_PDOWN && !(frame_end &&
       frm.opcode == `SFG_OP_RES)) |=> powered_down && !array_op_start)
      else $error("power-down left without release");
   a_busy_ignore: assert property ( // RQ8
      (state == sfg_pkg::SFG_ST_PROG && !array_op_done)
      |=> !array_op_start && $stable(array_req))
      else $error("instruction taken while busy");
   a_guard_refuse: assert property ( // RQ21
      (state == sfg_pkg::SFG_ST_IDLE && frame_end &&
       frm.opcode == `SFG_OP_PP && guarded(guard, frm.addr))
      |=> !array_op_start)
      else $error("program into guarded region");
   a_reserved_zero: assert property ( // RQ14
      status_byte[6:5] == 2'b00)
      else $error("reserved status bits not zero");
   a_wren_sets: assert property ( // RQ9
      (state == sfg_pkg::SFG_ST_IDLE && frame_end && puw_done &&
       frm.aligned && frm.opcode == `SFG_OP_WREN)
      |=> status_byte[`SFG_BIT_LATCH])
      else $error("write enable did not set latch");

   c_program: cover property (
      write_latch_flag ##[1:1000] array_op_start ##[1:1000] array_op_done);
   c_status_write: cover property (
      state == sfg_pkg::SFG_ST_WSR ##1 state == sfg_pkg::SFG_ST_IDLE);
   c_pdown_cycle: cover property (
      $rose(powered_down) ##[1:1000] $fell(powered_down));
endmodule : sfg_write_guard

// [sfg_host_model.sv]
// SPI host model that frames instructions and reads the status byte
`timescale 1ns/1ps
module sfg_host_model (
   output logic spi_clk,
   output logic spi_cs_n,
   output logic spi_di,
   input wire logic spi_do
);
   // ----------------------------------------
   // Serial frames
   // ----------------------------------------
   // Clock stands low and select high outside frames
   initial begin
      spi_clk = 1'b0;
      spi_cs_n = 1'b1;
      spi_di = 1'b0;
   end
   // Shift whole bytes MSB first, keep the last byte seen on DO
   task automatic frame(input logic [31:0] tx, input int nb,
      output logic [7:0] rx);
      rx = 8'h00;
      #1 spi_cs_n = 1'b0;
      #7;
      for (int i = 0; i < nb * 8; i++) begin
         spi_di = tx[31 - i];
         #16 spi_clk = 1'b1;
         rx = {rx[6:0], spi_do};
         #16 spi_clk = 1'b0;
      end
      #7 spi_cs_n = 1'b1;
      // Released line shows the inverse of its last value
      spi_di = ~spi_di;
      #120;
   endtask : frame
endmodule : sfg_host_model

// [tb_sfg_write_guard.sv]
// Self-checking bench for the serial flash write guard
`timescale 1ns/1ps
`include "sfg_defines.svh"
module tb_sfg_write_guard;
   localparam int PUW = 100;
   localparam int TW = 200;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic wp_n = 1'b1;
   logic op_done = 1'b0;
   logic spi_clk, spi_cs_n, spi_di, spi_do, spi_do_oe;
   logic array_op_start, powered_down;
   logic [7:0] status_byte;
   logic [7:0] rx;
   sfg_pkg::sfg_array_req_t array_req;
   int bad_count = 0;
   int checks = 0;
   int starts = 0;
   int cyc = 0;
   int wait_cnt = 0;
   int oe_cnt = 0;
   logic [23:0] bnd [4] = '{`SFG_P40_B1, `SFG_P40_B2, `SFG_P40_B3, 24'h0};
   // ----------------------------------------
   // Design, host and array stand-in
   // ----------------------------------------
   sfg_write_guard #(.DENSITY_MBIT(`SFG_DENS_4M), .PUW_CYCLES(PUW),
      .TW_CYCLES(TW)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
      .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_di(spi_di),
      .wp_n(wp_n), .array_op_done(op_done), .spi_do(spi_do),
      .spi_do_oe(spi_do_oe), .array_op_start(array_op_start),
      .array_req(array_req), .status_byte(status_byte),
      .powered_down(powered_down));
   sfg_host_model host_u (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
      .spi_di(spi_di), .spi_do(spi_do));
   // System clock
   always #5 clk_sys = ~clk_sys;
   // Done pulse a few cycles after each accepted array operation
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      op_done <= (wait_cnt == 1);
      if (array_op_start === 1'b1) begin
         starts <= starts + 1;
         wait_cnt <= 6;
      end else if (wait_cnt != 0) begin
         wait_cnt <= wait_cnt - 1;
      end
   end
   // Count serial clocks on which the design drives DO
   always @(posedge spi_clk) begin
      oe_cnt <= oe_cnt + int'(spi_do_oe);
   end
   // Cut a hang short
   always @(posedge clk_sys) begin
      if (cyc == 20000) begin
         bad_count++;
         conclude();
      end
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   // Compare at the falling edge, where outputs are settled
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      @(negedge clk_sys);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic op(input logic [31:0] tx, input int nb);
      host_u.frame(tx, nb, rx);
   endtask : op
   // Read the status byte and count the clocks with DO driven
   task automatic rds(input logic [7:0] v, input int m);
      int n;
      n = oe_cnt;
      op({8'h05, 24'h0}, 2);
      chk(rx, v);
      chk(oe_cnt - n, m);
   endtask : rds
   // Wait, bounded, for the busy bit to drop
   task automatic idle();
      for (int i = 0; i < 400 && status_byte[0] !== 1'b0; i++) begin
         @(posedge clk_sys);
      end
   endtask : idle
   task automatic wrs(input logic [7:0] v);
      op({8'h06, 24'h0}, 1);
      op({8'h01, v, 16'h0}, 2);
      idle();
   endtask : wrs
   // Enable, send one array instruction, see if it was started
   task automatic try(input logic [7:0] o, input logic [23:0] a,
      input int nb, input int acc, input sfg_pkg::sfg_kind_t k);
      int n;
      n = starts;
      op({8'h06, 24'h0}, 1);
      op({o, a}, nb);
      chk(starts, n + acc);
      if (acc == 1) begin
         chk(array_req, {k, a});
         idle();
         chk(status_byte[1:0], 2'b00);
      end
   endtask : try
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge clk_sys);
      chk(status_byte, 8'h00);
      @(posedge clk_sys);
      rst_n <= 1'b1;
      op({8'h06, 24'h0}, 1);
      chk(status_byte, 8'h00);
      repeat (PUW) @(posedge clk_sys);
      op({8'h06, 24'h0}, 1);
      chk(status_byte, 8'h02);
      rds(8'h02, 8);
      op({8'h04, 24'h0}, 1);
      chk(status_byte, 8'h00);
      op({8'h02, 24'h0}, 4);
      chk(starts, 0);
      $display("test latch done");
      op({8'h06, 24'h0}, 1);
      op({8'h01, 8'hff, 16'h0}, 2);
      op({8'h04, 24'h0}, 1);
      chk(status_byte, 8'h03);
      rds(8'h03, 8);
      idle();
      chk(status_byte, `SFG_MASK_4M);
      $display("test status write done");
      @(posedge clk_sys);
      wp_n <= 1'b0;
      wrs(8'h00);
      chk(status_byte, 8'h9e);
      @(posedge clk_sys);
      wp_n <= 1'b1;
      wrs(8'h00);
      chk(status_byte, 8'h00);
      @(posedge clk_sys);
      wp_n <= 1'b0;
      wrs(8'h0c);
      chk(status_byte, 8'h0c);
      $display("test lock done");
      for (int c = 1; c < 5; c++) begin
         wrs(8'(c << 2));
         if (c < 4) begin
            try(8'h02, bnd[c-1] - 24'h1, 4, 1, sfg_pkg::SFG_K_PROG);
         end
         try(8'h02, bnd[c-1], 4, 0, sfg_pkg::SFG_K_PROG);
      end
      try(8'hc7, 24'h0, 1, 0, sfg_pkg::SFG_K_BULK);
      wrs(8'h00);
      try(8'hd8, 24'h070000, 4, 1, sfg_pkg::SFG_K_SECT);
      try(8'hc7, 24'h0, 1, 1, sfg_pkg::SFG_K_BULK);
      $display("test regions done");
      op({8'h06, 24'h0}, 1);
      op({8'hb9, 24'h0}, 1);
      chk(powered_down, 1'b1);
      rds(8'h00, 0);
      op({8'h04, 24'h0}, 1);
      chk(status_byte, 8'h02);
      op({8'hab, 24'h0}, 1);
      chk(powered_down, 1'b0);
      op({8'h04, 24'h0}, 1);
      chk(status_byte, 8'h00);
      $display("test power-down done");
      conclude();
   end
endmodule : tb_sfg_write_guard
